// file: logic/fha_defines.svh
// constants of the fault handler: register offsets, fields, resets, timing
// assumes a 10 MHz system clock and byte addresses on an 8-bit bus address
`ifndef FHA_DEFINES_SVH
`define FHA_DEFINES_SVH
`define FHA_CLK_PERIOD_NS 100
`define FHA_TICK_TIME_NS 1000000
`define FHA_TICK_CYCLES (`FHA_TICK_TIME_NS / `FHA_CLK_PERIOD_NS)
`define FHA_HIST_DEPTH 3
`define FHA_SNAP_WORDS 6
`define FHA_ADDR_CTRL 8'h00
`define FHA_ADDR_DELAY 8'h04
`define FHA_ADDR_STATE 8'h08
`define FHA_ADDR_HIST 8'h0C
`define FHA_ADDR_SNAP0 8'h10
`define FHA_ADDR_SNAP5 8'h24
`define FHA_ADDR_IRQ_STAT 8'h28
`define FHA_ADDR_IRQ_CLR 8'h2C
`define FHA_ADDR_IRQ_EN 8'h30
`define FHA_CTRL_REACT_BIT 8
`define FHA_ATTEMPT_RST 8'h00
`define FHA_DELAY_RST 16'h03E8
`define FHA_IRQ_FAULT 0
`define FHA_IRQ_RESTART 1
`define FHA_IRQ_EXHAUST 2
`define FHA_IRQ_IGNORED 3
`define FHA_MAIN_LINK_LOST_CODE 8'hE2
`define FHA_REMOVABLE_LINK_LOST_CODE 8'hE6
`define FHA_FIRMWARE_MISMATCH_CODE 8'hE9
`define FHA_RESP_OKAY 2'h0
`define FHA_RESP_SLVERR 2'h2
`endif

// file: logic/fha_pkg.sv
// types shared by the fault handler modules
// constants live in fha_defines.svh
package fha_pkg;
  typedef logic [7:0] fha_code_t;
  typedef logic [5:0][15:0] fha_snap_t;
  typedef enum logic [4:0] {
    FHA_IDLE     = 5'h01,
    FHA_RUN      = 5'h02,
    FHA_STOPWAIT = 5'h04,
    FHA_DELAY    = 5'h08,
    FHA_HOLD     = 5'h10
  } fha_state_t;
  typedef enum logic {
    FHA_REACT_COAST  = 1'b0,
    FHA_REACT_IGNORE = 1'b1
  } fha_react_t;
endpackage

// file: logic/fha_hist_if.sv
// link between the fault controller and its history store
// driven from one clock domain only
`timescale 1ns/1ps
interface fha_hist_if;
  logic record;
  fha_pkg::fha_code_t code;
  fha_pkg::fha_snap_t status;
  logic [23:0] codes;
  fha_pkg::fha_snap_t snap;
  modport ctrl (output record, code, status, input codes, snap);
  modport store (input record, code, status, output codes, snap);
endinterface

// file: logic/fha_history.sv
// error history shift store and fault status snapshot
// record is a one-cycle pulse from the controller
`timescale 1ns/1ps
`include "fha_defines.svh"
module fha_history (
  input logic clk_in,
  input logic rst_n_in,
  fha_hist_if.store hist
);
  import fha_pkg::*;
  fha_code_t code_mem [`FHA_HIST_DEPTH];
  logic [15:0] snap_mem [`FHA_SNAP_WORDS];

  // newest in slot 0, oldest falls off the end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `FHA_HIST_DEPTH; i++)
        code_mem[i] <= 8'h00;
    end
    else if (hist.record)
    begin
      code_mem[0] <= hist.code;
      for (int i = 1; i < `FHA_HIST_DEPTH; i++)
        code_mem[i] <= code_mem[i-1];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `FHA_SNAP_WORDS; i++)
        snap_mem[i] <= 16'h0000;
    end
    else if (hist.record)
    begin
      for (int i = 0; i < `FHA_SNAP_WORDS; i++)
        snap_mem[i] <= hist.status[i];
    end
  end

  assign hist.codes = {code_mem[2], code_mem[1], code_mem[0]};
  always_comb
  begin
    for (int i = 0; i < `FHA_SNAP_WORDS; i++)
      hist.snap[i] = snap_mem[i];
  end

  hist_shift_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hist.record |=> hist.codes[7:0] == $past(hist.code)
      && hist.codes[23:8] == $past(hist.codes[15:0]))
    else $error("history did not shift on a new fault");
  snap_take_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hist.record |=> hist.snap == $past(hist.status))
    else $error("status snapshot not captured");
endmodule

// file: logic/fha_top.sv
// fault supervision with automatic restart, AXI4-Lite register slave
// assumes all inputs synchronous to REF_CLK_IN, event inputs one-cycle pulses
`timescale 1ns/1ps
`include "fha_defines.svh"
module fha_top #(
  parameter int TICK_CYCLES = `FHA_TICK_CYCLES
) (
  input logic REF_CLK_IN,
  input logic RESET_N_IN,
  input logic [7:0] S_AXI_AWADDR_IN,
  input logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input logic [31:0] S_AXI_WDATA_IN,
  input logic [3:0] S_AXI_WSTRB_IN,
  input logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input logic S_AXI_BREADY_IN,
  input logic [7:0] S_AXI_ARADDR_IN,
  input logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input logic S_AXI_RREADY_IN,
  input logic FAULT_VALID_IN,
  input fha_pkg::fha_code_t FAULT_CODE_IN,
  input logic MAIN_LINK_LOST_IN,
  input logic REMOVABLE_LINK_LOST_IN,
  input logic FIRMWARE_MISMATCH_IN,
  input fha_pkg::fha_snap_t STATUS_IN,
  input logic OUTPUT_STOPPED_IN,
  input logic STOP_KEY_IN,
  input logic OTHER_KEY_IN,
  input logic EXT_FAULT_RESET_IN,
  input logic EXT_RUN_IN,
  output logic DRIVE_ENABLE_OUT,
  output logic RUN_CMD_OUT,
  output logic FAULT_ACTIVE_OUT,
  output logic DISPLAY_FAULT_OUT,
  output fha_pkg::fha_code_t DISPLAY_OUT,
  output logic IRQ_OUT
);
  import fha_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `FHA_ADDR_IRQ_EN;
  endfunction

  fha_hist_if hist ();
  fha_history u_history (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .hist(hist)
  );

  fha_state_t state, next_state;
  logic [7:0] attempt_cfg;
  fha_react_t react_cfg;
  logic [15:0] delay_cfg;
  logic [3:0] irq_status, irq_enable, irq_set, irq_clr;
  logic [7:0] attempts;
  fha_code_t fault_code, take_code;
  logic [1:0] disp_mode;
  logic success_pending;
  logic [TW-1:0] tick_cnt;
  logic [15:0] delay_cnt;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  wire faulted = state inside {FHA_STOPWAIT, FHA_DELAY, FHA_HOLD};
  wire manual_clr = STOP_KEY_IN || EXT_FAULT_RESET_IN;
  wire comm_evt = MAIN_LINK_LOST_IN || REMOVABLE_LINK_LOST_IN;
  wire comm_used = comm_evt && react_cfg == FHA_REACT_COAST;
  wire gen_evt = FAULT_VALID_IN || FIRMWARE_MISMATCH_IN;
  wire fault_take = state == FHA_RUN && (comm_used || gen_evt);
  wire ignored = state == FHA_RUN && comm_evt && !comm_used;
  wire auto_ok = attempt_cfg != 8'h00 && attempts != 8'h00;
  wire timing = state == FHA_DELAY || (state == FHA_RUN && success_pending);
  wire period_done = delay_cnt == delay_cfg;
  wire auto_start = state == FHA_DELAY && !manual_clr && period_done;
  wire success = state == FHA_RUN && success_pending && !fault_take && period_done;

  // link-lost codes take priority, a firmware mismatch fills in otherwise
  always_comb
  begin
    take_code = FAULT_CODE_IN;
    if (comm_used && MAIN_LINK_LOST_IN)
      take_code = `FHA_MAIN_LINK_LOST_CODE;
    else if (comm_used)
      take_code = `FHA_REMOVABLE_LINK_LOST_CODE;
    else if (FIRMWARE_MISMATCH_IN)
      take_code = `FHA_FIRMWARE_MISMATCH_CODE;
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      FHA_IDLE:
        if (EXT_RUN_IN)
          next_state = FHA_RUN;
      FHA_RUN:
        if (fault_take)
          next_state = FHA_STOPWAIT;
        else if (STOP_KEY_IN)
          next_state = FHA_IDLE;
      FHA_STOPWAIT:
        if (manual_clr)
          next_state = FHA_IDLE;
        else if (OUTPUT_STOPPED_IN)
          next_state = auto_ok ? FHA_DELAY : FHA_HOLD;
      FHA_DELAY:
        if (manual_clr)
          next_state = FHA_IDLE;
        else if (period_done)
          next_state = FHA_RUN;
      FHA_HOLD:
        if (manual_clr)
          next_state = FHA_IDLE;
      default:
        next_state = FHA_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      state <= FHA_IDLE;
    else
      state <= next_state;
  end

  // delay and success window share one millisecond timebase
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tick_cnt <= '0;
      delay_cnt <= 16'h0000;
    end
    else if (!timing || next_state != state || period_done)
    begin
      tick_cnt <= '0;
      delay_cnt <= 16'h0000;
    end
    else if (tick_cnt == TW'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      delay_cnt <= delay_cnt + 16'h0001;
    end
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      attempts <= 8'h00;
    else if (state == FHA_IDLE && EXT_RUN_IN)
      attempts <= attempt_cfg;
    else if (faulted && manual_clr)
      attempts <= 8'h00;
    else if (auto_start)
      attempts <= attempts - 8'h01;
    else if (success)
      attempts <= attempt_cfg;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      success_pending <= 1'b0;
    else if (auto_start)
      success_pending <= 1'b1;
    else if (success || state != FHA_RUN || fault_take)
      success_pending <= 1'b0;
  end

  // an ignored error leaves both the display and the history untouched
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      fault_code <= 8'h00;
      hist.record <= 1'b0;
      hist.code <= 8'h00;
      hist.status <= '0;
    end
    else
    begin
      hist.record <= fault_take;
      hist.code <= take_code;
      hist.status <= STATUS_IN;
      if (fault_take)
        fault_code <= take_code;
    end
  end

  // display mode is frozen while faulted, so clearing restores it
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      disp_mode <= 2'h0;
    else if (OTHER_KEY_IN && !faulted)
      disp_mode <= disp_mode + 2'h1;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      DRIVE_ENABLE_OUT <= 1'b0;
      RUN_CMD_OUT <= 1'b0;
      FAULT_ACTIVE_OUT <= 1'b0;
      DISPLAY_FAULT_OUT <= 1'b0;
      DISPLAY_OUT <= 8'h00;
    end
    else
    begin
      DRIVE_ENABLE_OUT <= next_state == FHA_RUN;
      RUN_CMD_OUT <= next_state == FHA_RUN && state != FHA_RUN;
      FAULT_ACTIVE_OUT <= next_state inside {FHA_STOPWAIT, FHA_DELAY, FHA_HOLD};
      DISPLAY_FAULT_OUT <= next_state inside {FHA_STOPWAIT, FHA_DELAY, FHA_HOLD};
      if (fault_take)
        DISPLAY_OUT <= take_code;
      else if (!(next_state inside {FHA_STOPWAIT, FHA_DELAY, FHA_HOLD}))
        DISPLAY_OUT <= {6'h00, disp_mode};
    end
  end

  always_comb
  begin
    irq_set = 4'h0;
    irq_set[`FHA_IRQ_FAULT] = fault_take;
    irq_set[`FHA_IRQ_RESTART] = auto_start;
    irq_set[`FHA_IRQ_EXHAUST] = state == FHA_STOPWAIT && !manual_clr
      && OUTPUT_STOPPED_IN && attempt_cfg != 8'h00 && attempts == 8'h00;
    irq_set[`FHA_IRQ_IGNORED] = ignored;
    irq_clr = 4'h0;
    if (do_write && aw_addr == `FHA_ADDR_IRQ_CLR && w_strb[0])
      irq_clr = w_data[3:0];
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      irq_status <= 4'h0;
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      IRQ_OUT <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
    end
  end

  // write channel: address and data taken in any order, answered together
  assign do_write = !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT <= 1'b1;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= `FHA_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        S_AXI_AWREADY_OUT <= 1'b0;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        S_AXI_WREADY_OUT <= 1'b0;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      if (do_write)
      begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= mapped(aw_addr) ? `FHA_RESP_OKAY : `FHA_RESP_SLVERR;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
      begin
        S_AXI_BVALID_OUT <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      attempt_cfg <= `FHA_ATTEMPT_RST;
      react_cfg <= FHA_REACT_COAST;
      delay_cfg <= `FHA_DELAY_RST;
      irq_enable <= 4'h0;
    end
    else if (do_write)
    begin
      unique case (aw_addr)
        `FHA_ADDR_CTRL:
        begin
          attempt_cfg <= 8'(merge_strb({24'h0, attempt_cfg}, w_data, w_strb));
          if (w_strb[1])
            react_cfg <= fha_react_t'(w_data[`FHA_CTRL_REACT_BIT]);
        end
        `FHA_ADDR_DELAY:
          delay_cfg <= 16'(merge_strb({16'h0, delay_cfg}, w_data, w_strb));
        `FHA_ADDR_IRQ_EN:
          irq_enable <= 4'(merge_strb({28'h0, irq_enable}, w_data, w_strb));
        default:
          ;
      endcase
    end
  end

  // read channel: one read in flight, data one cycle after the address
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h00000000;
      S_AXI_RRESP_OUT <= `FHA_RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT <= mapped(S_AXI_ARADDR_IN) ? `FHA_RESP_OKAY : `FHA_RESP_SLVERR;
      S_AXI_RDATA_OUT <= 32'h00000000;
      if (S_AXI_ARADDR_IN >= `FHA_ADDR_SNAP0 && S_AXI_ARADDR_IN <= `FHA_ADDR_SNAP5)
        S_AXI_RDATA_OUT <= {16'h0000,
          hist.snap[3'((S_AXI_ARADDR_IN - `FHA_ADDR_SNAP0) >> 2)]};
      else
        unique case (S_AXI_ARADDR_IN)
          `FHA_ADDR_CTRL: S_AXI_RDATA_OUT <= {23'h0, react_cfg, attempt_cfg};
          `FHA_ADDR_DELAY: S_AXI_RDATA_OUT <= {16'h0, delay_cfg};
          `FHA_ADDR_STATE:
            S_AXI_RDATA_OUT <= {attempts, fault_code, 6'h00, disp_mode, 3'h0, state};
          `FHA_ADDR_HIST: S_AXI_RDATA_OUT <= {8'h00, hist.codes};
          `FHA_ADDR_IRQ_STAT: S_AXI_RDATA_OUT <= {28'h0, irq_status};
          `FHA_ADDR_IRQ_EN: S_AXI_RDATA_OUT <= {28'h0, irq_enable};
          default: S_AXI_RDATA_OUT <= 32'h00000000;
        endcase
    end
    else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
    begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_ARREADY_OUT <= 1'b1;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  coast_stop_a: assert property (fault_take |=> !DRIVE_ENABLE_OUT ##1 !DRIVE_ENABLE_OUT)
    else $error("drive still enabled after fault");
  comm_react_a: assert property (ignored && !gen_evt && !STOP_KEY_IN
    |=> state == FHA_RUN)
    else $error("ignored link error stopped the drive");
  ignore_quiet_a: assert property (ignored && !gen_evt |=> !hist.record && !DISPLAY_FAULT_OUT)
    else $error("ignored error was shown or recorded");
  manual_clear_a: assert property (faulted && manual_clr |=> state == FHA_IDLE ##1 !FAULT_ACTIVE_OUT)
    else $error("manual reset did not clear the fault");
  lockout_run_a: assert property (faulted && EXT_RUN_IN && !manual_clr && !auto_start
    |=> !RUN_CMD_OUT && $stable(disp_mode))
    else $error("input accepted while faulted");
  display_back_a: assert property (faulted && manual_clr
    |=> ##1 DISPLAY_OUT == {6'h00, $past(disp_mode, 2)})
    else $error("display not restored");
  auto_gate_a: assert property (state == FHA_STOPWAIT && OUTPUT_STOPPED_IN && !manual_clr
    && attempt_cfg == 8'h00 |=> state == FHA_HOLD)
    else $error("restart armed with zero attempt count");
  auto_restart_a: assert property (auto_start |=> state == FHA_RUN && RUN_CMD_OUT
    && attempts == $past(attempts) - 8'h01)
    else $error("restart not issued after delay");
  retry_limit_a: assert property (state == FHA_STOPWAIT && OUTPUT_STOPPED_IN && !manual_clr
    && attempts == 8'h00 |=> state == FHA_HOLD ##1 state inside {FHA_HOLD, FHA_IDLE})
    else $error("restart beyond the attempt limit");
  abort_seq_a: assert property (state == FHA_DELAY && manual_clr
    |=> state == FHA_IDLE && attempts == 8'h00)
    else $error("manual reset did not abort restart");
  reload_cnt_a: assert property (success |=> attempts == $past(attempt_cfg) && !success_pending)
    else $error("attempts not reloaded after success");
  link_code_a: assert property (fault_take && comm_used && MAIN_LINK_LOST_IN
    |=> fault_code == `FHA_MAIN_LINK_LOST_CODE)
    else $error("wrong code for main link loss");
endmodule

// file: sim/fha_panel_model.sv
// operator panel keys and the digital fault reset input
// press_in picks key_in (0 stop, 1 other, 2 ext reset, 3 ext run) for one cycle
`timescale 1ns/1ps
module fha_panel_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic press_in,
  input wire logic [1:0] key_in,
  output logic stop_out,
  output logic other_out,
  output logic reset_out,
  output logic run_out
);
  // keys are debounced upstream, so every press is one clean cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stop_out <= 1'b0;
      other_out <= 1'b0;
      reset_out <= 1'b0;
      run_out <= 1'b0;
    end
    else
    begin
      stop_out <= press_in && key_in == 2'h0;
      other_out <= press_in && key_in == 2'h1;
      reset_out <= press_in && key_in == 2'h2;
      run_out <= press_in && key_in == 2'h3;
    end
  end
endmodule

// file: sim/testbench.sv
// self-checking bench of the fault handler with automatic restart
// assumes the panel model on the key inputs; stimulus changes on rising edges
`timescale 1ns/1ps
`include "fha_defines.svh"
module testbench;
  import fha_pkg::*;
  localparam int TK = 4;
  logic clk = 1'b0, rst_n = 1'b0, stp = 1'b1, pr = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] evt = 4'h0;
  logic [1:0] kk = 2'h0;
  fha_code_t code = 8'h00;
  fha_snap_t st;
  logic awr, wrd, bv, arr, rv, drv, runc, fa, dfl, irq, k_stop, k_oth, k_rst, k_run;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  fha_code_t disp;
  int miscompares = 0, num_checks = 0, cyc = 0;

  fha_top #(.TICK_CYCLES(TK)) i_dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .FAULT_VALID_IN(evt[0]),
    .FAULT_CODE_IN(code), .MAIN_LINK_LOST_IN(evt[1]), .REMOVABLE_LINK_LOST_IN(evt[2]),
    .FIRMWARE_MISMATCH_IN(evt[3]), .STATUS_IN(st), .OUTPUT_STOPPED_IN(stp),
    .STOP_KEY_IN(k_stop), .OTHER_KEY_IN(k_oth), .EXT_FAULT_RESET_IN(k_rst),
    .EXT_RUN_IN(k_run), .DRIVE_ENABLE_OUT(drv), .RUN_CMD_OUT(runc),
    .FAULT_ACTIVE_OUT(fa), .DISPLAY_FAULT_OUT(dfl), .DISPLAY_OUT(disp), .IRQ_OUT(irq));
  fha_panel_model i_panel (.clk_in(clk), .rst_n_in(rst_n), .press_in(pr), .key_in(kk),
    .stop_out(k_stop), .other_out(k_oth), .reset_out(k_rst), .run_out(k_run));

  always #50 clk = ~clk;
  // power stage reports stopped one cycle after the drive drops
  always @(posedge clk) stp <= !drv;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // levels are {drive, fault, display fault, irq}, looked at mid-cycle
  task automatic pchk(input logic [3:0] e, input fha_code_t ed);
    @(negedge clk);
    chk("levels", {28'h0, e}, {28'h0, drv, fa, dfl, irq});
    chk("display", {24'h0, ed}, {24'h0, disp});
    @(posedge clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1);
    br <= 1'b0;
    // one idle edge so a following call never re-drives in this time step
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(n, e, d & m);
  endtask

  task automatic key(input logic [1:0] k);
    kk <= k;
    pr <= 1'b1;
    @(posedge clk);
    pr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic fault(input logic [3:0] e, input fha_code_t c);
    evt <= e;
    code <= c;
    @(posedge clk);
    evt <= 4'h0;
  endtask

  task automatic wait_run(input int b, input logic e);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (runc !== 1'b1 && n < b);
    chk("run command", {31'h0, e}, {31'h0, runc});
  endtask

  // manual run, one error, then stop key from the held fault
  task automatic trip(input logic [3:0] e, input fha_code_t c);
    key(2'h3);
    fault(e, c);
    repeat (3) @(posedge clk);
    key(2'h0);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("delay reset", `FHA_ADDR_DELAY, 32'hFFFFFFFF, 32'h000003E8);
    rd_chk("ctrl reset", `FHA_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    axr(8'h34, d, r);
    chk("unmapped resp", `FHA_RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    axw(8'h34, 32'hF);
    chk("unmapped write resp", `FHA_RESP_SLVERR, bresp);
    axw(`FHA_ADDR_DELAY, 32'h3E8);
    chk("write resp", `FHA_RESP_OKAY, bresp);
  endtask

  task automatic t_coast();
    axw(`FHA_ADDR_IRQ_EN, 32'h1);
    key(2'h3);
    key(2'h1);
    pchk(4'b1000, 8'h01);
    fault(4'h1, 8'h5A);
    pchk(4'b0111, 8'h5A);
    wait_run(30, 1'b0);
    key(2'h1);
    key(2'h3);
    pchk(4'b0111, 8'h5A);
    key(2'h0);
    pchk(4'b0001, 8'h01);
    rd_chk("snapshot first", `FHA_ADDR_SNAP0, 32'hFFFF, 32'h1100);
    rd_chk("snapshot last", `FHA_ADDR_SNAP5, 32'hFFFF, 32'h1105);
    axw(`FHA_ADDR_IRQ_CLR, 32'h1);
    pchk(4'b0000, 8'h01);
    key(2'h3);
    fault(4'h1, 8'h5B);
    repeat (3) @(posedge clk);
    key(2'h2);
    pchk(4'b0001, 8'h01);
  endtask

  task automatic t_hist();
    trip(4'h2, 8'h00);
    trip(4'h4, 8'h00);
    trip(4'h8, 8'h00);
    rd_chk("history", `FHA_ADDR_HIST, 32'hFFFFFFFF, 32'h00E2E6E9);
    trip(4'h1, 8'h33);
    rd_chk("history shift", `FHA_ADDR_HIST, 32'hFFFFFFFF, 32'h00E6E933);
  endtask

  task automatic t_ignore();
    axw(`FHA_ADDR_CTRL, 32'h100);
    axw(`FHA_ADDR_IRQ_CLR, 32'hF);
    axw(`FHA_ADDR_IRQ_EN, 32'h8);
    key(2'h3);
    fault(4'h2, 8'h00);
    pchk(4'b1001, 8'h01);
    rd_chk("history kept", `FHA_ADDR_HIST, 32'hFFFFFFFF, 32'h00E6E933);
    key(2'h0);
  endtask

  task automatic t_auto();
    axw(`FHA_ADDR_IRQ_CLR, 32'hF);
    axw(`FHA_ADDR_DELAY, 32'h2);
    axw(`FHA_ADDR_CTRL, 32'h2);
    key(2'h3);
    fault(4'h1, 8'h44);
    wait_run(60, 1'b1);
    pchk(4'b1000, 8'h01);
    repeat (30) @(posedge clk);
    rd_chk("attempts reload", `FHA_ADDR_STATE, 32'hFF000000, 32'h02000000);
    fault(4'h1, 8'h44);
    wait_run(60, 1'b1);
    fault(4'h1, 8'h44);
    wait_run(60, 1'b1);
    fault(4'h1, 8'h44);
    wait_run(60, 1'b0);
    rd_chk("held state", `FHA_ADDR_STATE, 32'h1F, FHA_HOLD);
    rd_chk("restart events", `FHA_ADDR_IRQ_STAT, 32'h6, 32'h6);
    key(2'h0);
  endtask

  // a long delay leaves room to press stop inside it
  task automatic t_abort();
    axw(`FHA_ADDR_DELAY, 32'h5);
    key(2'h3);
    fault(4'h1, 8'h45);
    repeat (3) @(posedge clk);
    rd_chk("in delay", `FHA_ADDR_STATE, 32'h1F, FHA_DELAY);
    key(2'h0);
    wait_run(60, 1'b0);
    pchk(4'b0000, 8'h01);
    rd_chk("idle after abort", `FHA_ADDR_STATE, 32'h1F, FHA_IDLE);
  endtask

  initial
  begin
    for (int i = 0; i < 6; i++) st[i] = 16'(16'h1100 + i);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_coast();
    t_hist();
    t_ignore();
    t_auto();
    t_abort();
    give_verdict();
  end
endmodule
